// ### dio_pkg.sv
// Constants shared by the digital port block
`default_nettype none

package dio_pkg;

  // I/O space locations
  localparam logic [11:0] ADDR_PRIMARY_DATA   = 12'hEC0;
  localparam logic [11:0] ADDR_SECONDARY_DATA = 12'hEC1;
  localparam logic [11:0] ADDR_WINDOW         = 12'hEC2;
  localparam logic [11:0] ADDR_MODE_CONTROL   = 12'hEC3;

  // Control register fields
  localparam int CTL_SEL_LSB  = 0;
  localparam int CTL_SEC_DIR  = 2;
  localparam int CTL_MODE_LSB = 3;
  localparam int CTL_HIT      = 6;

  // Window selection by control bits 1:0
  typedef enum logic [1:0] {
    SEL_CLEAR     = 2'h0,
    SEL_DIRECTION = 2'h1,
    SEL_MASK      = 2'h2,
    SEL_COMPARE   = 2'h3
  } window_sel_t;

  // Interrupt modes in control bits 4:3
  typedef enum logic [1:0] {
    MODE_OFF    = 2'h0,
    MODE_STROBE = 2'h1,
    MODE_EVENT  = 2'h2,
    MODE_MATCH  = 2'h3
  } irq_mode_t;

  // Reset value, all-masked pattern and control write mask
  localparam logic [7:0] RESET_BYTE    = 8'h00;
  localparam logic [7:0] ALL_MASKED    = 8'hFF;
  localparam logic [7:0] CONTROL_WMASK = 8'h1F;

  // Sampling tick from the 20 MHz clock, fractional accumulator
  localparam int CLK_RATE_KHZ    = 20000;
  localparam int SAMPLE_RATE_KHZ = 8330;
  localparam logic [14:0] ACC_STEP = 15'(SAMPLE_RATE_KHZ);
  localparam logic [14:0] ACC_WRAP = 15'(CLK_RATE_KHZ);

  // Deglitch: shortest pulse that may register, in ns
  localparam int CLK_PERIOD_NS = 50;
  localparam int GLITCH_NS     = 60;
  localparam int FILTER_CYCLES = (GLITCH_NS / CLK_PERIOD_NS) < 1 ? 1
                                 : (GLITCH_NS / CLK_PERIOD_NS);
  localparam logic [1:0] FILTER_CNT = 2'(FILTER_CYCLES);

  // Interrupt line routing codes
  localparam logic [2:0] ROUTE_NONE = 3'h0;
  localparam int         IRQ_LINES  = 5;

endpackage

`default_nettype wire

// ### dio_port_sampler.sv
// Synchroniser, deglitch filter and 8.33 MHz sampler for the primary port
`timescale 1ns/100ps
`default_nettype none

module dio_port_sampler (
  // Clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst_n,
  // Pins
  input  wire logic [7:0] i_pins,
  // Results
  output logic      [7:0] o_pins_sync,
  output logic      [7:0] o_sample,
  output logic            o_sample_valid
);

  logic [7:0]  meta_q;
  logic [7:0]  sync_q;
  logic [7:0]  clean_q;
  logic [14:0] acc_q;
  logic [14:0] acc_sum;
  logic        tick;

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q <= dio_pkg::RESET_BYTE;
      sync_q <= dio_pkg::RESET_BYTE;
    end else begin
      meta_q <= i_pins;
      sync_q <= meta_q;
    end
  end

  assign o_pins_sync = sync_q;

  // A bit is accepted only after it stayed stable, so short glitches die here.
  // Accepted level held until a tick takes it; 120 ns pulses never slip between ticks
  genvar b;
  generate
    for (b = 0; b < 8; b++) begin : g_filter
      logic [1:0] stable_q;
      logic       held_q;
      logic       accept;
      assign accept = (sync_q[b] != clean_q[b]) && !held_q
                      && (stable_q >= dio_pkg::FILTER_CNT);
      always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          stable_q   <= 2'h0;
          clean_q[b] <= 1'b0;
        end else if (sync_q[b] == clean_q[b]) begin
          stable_q <= 2'h0;
        end else if (accept) begin
          clean_q[b] <= sync_q[b];
          stable_q   <= 2'h0;
        end else if (stable_q < dio_pkg::FILTER_CNT) begin
          stable_q <= stable_q + 2'h1;
        end
      end
      always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          held_q <= 1'b0;
        end else if (accept) begin
          held_q <= 1'b1;
        end else if (tick) begin
          held_q <= 1'b0;
        end
      end
    end
  endgenerate

  // Average rate of 8.33 MHz; ticks come 2 or 3 clocks apart
  assign acc_sum = acc_q + dio_pkg::ACC_STEP;
  assign tick    = (acc_sum >= dio_pkg::ACC_WRAP);

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      acc_q          <= 15'h0000;
      o_sample       <= dio_pkg::RESET_BYTE;
      o_sample_valid <= 1'b0;
    end else if (tick) begin
      acc_q          <= acc_sum - dio_pkg::ACC_WRAP;
      o_sample       <= clean_q;
      o_sample_valid <= 1'b1;
    end else begin
      acc_q          <= acc_sum;
      o_sample_valid <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ### dio_port.sv
// Twelve-line digital port with strobe, event and match interrupts
//
// What this block does
// - Primary bits individually input or output
// - Primary data write drives output pins
// - Secondary port bits 3:0, one direction
// - Secondary output: read returns last written
// - Window register selected by control bits 1:0
// - Reading clear register clears pending interrupts
// - Writing clear register zeroes five registers
// - Direction bit one means output
// - Mask one excludes bit from comparison
// - All bits masked disables comparator
// - Compare readable, writable, matched in match mode
// - Match or event sets control bit 6
// - Mode 10 event, mode 11 match
// - Deglitched 8.33 MHz sampling into compare
// - Mode 01 strobe rising edge interrupts
// - Strobe request holds until clear read
// - Strobe latches port, locks until compare read
// - Request routed to one of five lines
// - Event mode: unmasked bit change interrupts
// - Match mode: unmasked bits equal pattern
// - Power-up clears registers, all lines input
`timescale 1ns/100ps
`default_nettype none

module dio_port (
  // Clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_reset_n,
  // Host I/O access, one-cycle strobes
  input  wire logic [11:0] i_io_addr,
  input  wire logic        i_io_rd,
  input  wire logic        i_io_wr,
  input  wire logic [7:0]  i_io_wdata,
  output logic      [7:0]  o_io_rdata,
  // Primary port pins
  input  wire logic [7:0]  i_primary_port_bit,
  output logic      [7:0]  o_primary_port_bit,
  output logic      [7:0]  o_primary_port_oe,
  // Secondary port pins
  input  wire logic [3:0]  i_secondary_port_bit,
  output logic      [3:0]  o_secondary_port_bit,
  output logic      [3:0]  o_secondary_port_oe,
  // Strobe pin
  input  wire logic        i_strobe,
  // Interrupt routing
  input  wire logic [2:0]  i_irq_route,
  output logic      [4:0]  o_irq_lines
);

  logic       rst_meta_q;
  logic       rst_n_q;
  logic [7:0] primary_data_q;
  logic [3:0] secondary_data_q;
  logic [7:0] direction_q;
  logic [7:0] mask_q;
  logic [7:0] compare_q;
  logic [7:0] control_q;
  logic       pending_q;
  logic       strobe_lock_q;
  logic [3:0] sec_meta_q;
  logic [3:0] sec_sync_q;
  logic       stb_meta_q;
  logic       stb_sync_q;
  logic       stb_prev_q;
  logic [7:0] pins_sync;
  logic [7:0] sample;
  logic       sample_valid;

  logic       wr_primary;
  logic       wr_secondary;
  logic       wr_window;
  logic       wr_control;
  logic       rd_window;
  logic       board_clear;
  logic       irq_clear;
  logic       compare_read;
  logic       comparator_on;
  logic       event_hit;
  logic       match_hit;
  logic       strobe_hit;
  logic       hit;
  logic       irq_req;
  logic [7:0] primary_read;
  logic [7:0] secondary_read;
  logic [7:0] window_read;

  dio_pkg::window_sel_t sel;
  dio_pkg::irq_mode_t   mode;

  // Reset release through two flops
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  dio_port_sampler dio_port_sampler_inst (
    .i_ref_clk      (i_ref_clk),
    .i_rst_n        (rst_n_q),
    .i_pins         (i_primary_port_bit),
    .o_pins_sync    (pins_sync),
    .o_sample       (sample),
    .o_sample_valid (sample_valid)
  );

  // Secondary pins and strobe synchronisers
  always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sec_meta_q <= 4'h0;
      sec_sync_q <= 4'h0;
      stb_meta_q <= 1'b0;
      stb_sync_q <= 1'b0;
      stb_prev_q <= 1'b0;
    end else begin
      sec_meta_q <= i_secondary_port_bit;
      sec_sync_q <= sec_meta_q;
      stb_meta_q <= i_strobe;
      stb_sync_q <= stb_meta_q;
      stb_prev_q <= stb_sync_q;
    end
  end

  assign sel  = dio_pkg::window_sel_t'(control_q[dio_pkg::CTL_SEL_LSB +: 2]);
  assign mode = dio_pkg::irq_mode_t'(control_q[dio_pkg::CTL_MODE_LSB +: 2]);

  // Address decode
  assign wr_primary   = i_io_wr && (i_io_addr == dio_pkg::ADDR_PRIMARY_DATA);
  assign wr_secondary = i_io_wr && (i_io_addr == dio_pkg::ADDR_SECONDARY_DATA);
  assign wr_window    = i_io_wr && (i_io_addr == dio_pkg::ADDR_WINDOW);
  assign wr_control   = i_io_wr && (i_io_addr == dio_pkg::ADDR_MODE_CONTROL);
  assign rd_window    = i_io_rd && (i_io_addr == dio_pkg::ADDR_WINDOW);
  assign board_clear  = wr_window && (sel == dio_pkg::SEL_CLEAR);
  assign irq_clear    = rd_window && (sel == dio_pkg::SEL_CLEAR);
  assign compare_read = rd_window && (sel == dio_pkg::SEL_COMPARE);

  // Detection
  assign comparator_on = (mask_q != dio_pkg::ALL_MASKED);
  assign event_hit = sample_valid && comparator_on && (mode == dio_pkg::MODE_EVENT)
                     && (((sample ^ compare_q) & ~mask_q) != 8'h00);
  assign match_hit = sample_valid && comparator_on && (mode == dio_pkg::MODE_MATCH)
                     && (((sample ^ compare_q) & ~mask_q) == 8'h00);
  assign strobe_hit = (mode == dio_pkg::MODE_STROBE) && stb_sync_q && !stb_prev_q
                      && !strobe_lock_q;
  assign hit = event_hit || match_hit;

  // Primary port data and direction
  always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      primary_data_q <= dio_pkg::RESET_BYTE;
      direction_q    <= dio_pkg::RESET_BYTE;
    end else begin
      if (board_clear) begin
        primary_data_q <= dio_pkg::RESET_BYTE;
      end else if (wr_primary) begin
        primary_data_q <= i_io_wdata;
      end
      if (wr_window && (sel == dio_pkg::SEL_DIRECTION)) begin
        direction_q <= i_io_wdata;
      end
    end
  end

  assign o_primary_port_bit = primary_data_q;
  assign o_primary_port_oe  = direction_q;
  assign primary_read = (primary_data_q & direction_q) | (pins_sync & ~direction_q);

  // Secondary port data
  always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      secondary_data_q <= 4'h0;
    end else if (board_clear) begin
      secondary_data_q <= 4'h0;
    end else if (wr_secondary) begin
      secondary_data_q <= i_io_wdata[3:0];
    end
  end

  assign o_secondary_port_bit = secondary_data_q;
  assign o_secondary_port_oe  = {4{control_q[dio_pkg::CTL_SEC_DIR]}};
  assign secondary_read = {4'h0, control_q[dio_pkg::CTL_SEC_DIR] ? secondary_data_q
                                                                 : sec_sync_q};

  // Mask register
  always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      mask_q <= dio_pkg::RESET_BYTE;
    end else if (board_clear) begin
      mask_q <= dio_pkg::RESET_BYTE;
    end else if (wr_window && (sel == dio_pkg::SEL_MASK)) begin
      mask_q <= i_io_wdata;
    end
  end

  // Compare register: written by software, loaded by sampler or strobe
  always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      compare_q <= dio_pkg::RESET_BYTE;
    end else if (board_clear) begin
      compare_q <= dio_pkg::RESET_BYTE;
    end else if (strobe_hit) begin
      compare_q <= pins_sync;
    end else if (sample_valid && (mode == dio_pkg::MODE_EVENT)) begin
      compare_q <= sample;
    end else if (wr_window && (sel == dio_pkg::SEL_COMPARE)) begin
      compare_q <= i_io_wdata;
    end
  end

  // Strobe lock: a new strobe wins over a compare read in the same cycle
  always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      strobe_lock_q <= 1'b0;
    end else if (strobe_hit) begin
      strobe_lock_q <= 1'b1;
    end else if (compare_read || board_clear) begin
      strobe_lock_q <= 1'b0;
    end
  end

  // Control register; bit 6 is set by hardware, set beats clear
  always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      control_q <= dio_pkg::RESET_BYTE;
    end else begin
      if (board_clear) begin
        control_q[5:0] <= 6'h00;
        control_q[7]   <= 1'b0;
      end else if (wr_control) begin
        control_q[4:0] <= i_io_wdata[4:0];
      end
      if (hit) begin
        control_q[dio_pkg::CTL_HIT] <= 1'b1;
      end else if (board_clear || irq_clear) begin
        control_q[dio_pkg::CTL_HIT] <= 1'b0;
      end
    end
  end

  // Pending request; an event in the clearing cycle is kept
  always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pending_q <= 1'b0;
    end else if (hit || strobe_hit) begin
      pending_q <= 1'b1;
    end else if (irq_clear || board_clear) begin
      pending_q <= 1'b0;
    end
  end

  assign irq_req = pending_q && (mode != dio_pkg::MODE_OFF);

  // One-hot routing onto lines 3, 5, 6, 10, 11 (codes 1 to 5)
  genvar l;
  generate
    for (l = 0; l < dio_pkg::IRQ_LINES; l++) begin : g_route
      assign o_irq_lines[l] = irq_req && (i_irq_route == 3'(l + 1));
    end
  endgenerate

  // Window read mux; the clear and write-only slots read back as zero
  always_comb begin
    unique case (sel)
      dio_pkg::SEL_CLEAR:     window_read = 8'h00;
      dio_pkg::SEL_DIRECTION: window_read = 8'h00;
      dio_pkg::SEL_MASK:      window_read = 8'h00;
      dio_pkg::SEL_COMPARE:   window_read = compare_q;
    endcase
  end

  // Read data registered, valid the cycle after the read strobe
  always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      o_io_rdata <= dio_pkg::RESET_BYTE;
    end else if (i_io_rd) begin
      unique case (i_io_addr)
        dio_pkg::ADDR_PRIMARY_DATA:   o_io_rdata <= primary_read;
        dio_pkg::ADDR_SECONDARY_DATA: o_io_rdata <= secondary_read;
        dio_pkg::ADDR_WINDOW:         o_io_rdata <= window_read;
        dio_pkg::ADDR_MODE_CONTROL:   o_io_rdata <= control_q;
        default:                      o_io_rdata <= 8'h00;
      endcase
    end
  end

endmodule

`default_nettype wire

// ### dio_port_props.sv
// Port-level assertions for the digital port block
`timescale 1ns/100ps
`default_nettype none

module dio_port_props (
  // Clock and reset
  input wire logic        i_ref_clk,
  input wire logic        i_reset_n,
  // Host access
  input wire logic [11:0] i_io_addr,
  input wire logic        i_io_rd,
  input wire logic        i_io_wr,
  input wire logic [7:0]  i_io_wdata,
  input wire logic [7:0]  o_io_rdata,
  // Pins and requests
  input wire logic [7:0]  o_primary_port_bit,
  input wire logic [7:0]  o_primary_port_oe,
  input wire logic [3:0]  o_secondary_port_bit,
  input wire logic [3:0]  o_secondary_port_oe,
  input wire logic [2:0]  i_irq_route,
  input wire logic [4:0]  o_irq_lines
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);

  logic [1:0] sel_q;
  logic       mapped;
  assign mapped = i_io_addr inside {[12'hEC0:12'hEC3]};

  // Window select shadow; a clear write leaves it at zero anyway
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) sel_q <= 2'h0;
    else if (i_io_wr && i_io_addr == 12'hEC3) sel_q <= i_io_wdata[1:0];
  end

  a_primary_write: assert property (i_io_wr && i_io_addr == 12'hEC0 |=>
    o_primary_port_bit == $past(i_io_wdata)) else $error("primary data not stored");
  a_out_readback: assert property (i_io_rd && i_io_addr == 12'hEC0 |=>
    ((o_io_rdata ^ $past(o_primary_port_bit)) & $past(o_primary_port_oe)) == 8'h00)
    else $error("output bit readback wrong");
  a_dir_write: assert property (i_io_wr && i_io_addr == 12'hEC2 && sel_q == 2'h1 |=>
    o_primary_port_oe == $past(i_io_wdata)) else $error("direction not stored");
  a_sec_write: assert property (i_io_wr && i_io_addr == 12'hEC1 |=>
    o_secondary_port_bit == $past(i_io_wdata[3:0])) else $error("secondary not stored");
  a_sec_dir: assert property (i_io_wr && i_io_addr == 12'hEC3 |=>
    o_secondary_port_oe == {4{$past(i_io_wdata[2])}}) else $error("secondary dir wrong");
  a_sec_upper: assert property (i_io_rd && i_io_addr == 12'hEC1 |=>
    o_io_rdata[7:4] == 4'h0) else $error("secondary upper bits set");
  a_clear_write: assert property (i_io_wr && i_io_addr == 12'hEC2 && sel_q == 2'h0 |=>
    o_primary_port_bit == 8'h00 && o_secondary_port_bit == 4'h0 && o_secondary_port_oe == 4'h0)
    else $error("clear write left data");
  a_unmapped_read: assert property (i_io_rd && !mapped |=> o_io_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property (!i_io_rd |=> $stable(o_io_rdata))
    else $error("read data changed without read");
  a_irq_route: assert property (o_irq_lines == 5'h00 || (i_irq_route inside {[3'h1:3'h5]}
    && o_irq_lines == 5'(5'h01 << (i_irq_route - 3'h1)))) else $error("request misrouted");
endmodule

bind dio_port dio_port_props dio_port_props_inst (
  .i_ref_clk            (i_ref_clk),
  .i_reset_n            (i_reset_n),
  .i_io_addr            (i_io_addr),
  .i_io_rd              (i_io_rd),
  .i_io_wr              (i_io_wr),
  .i_io_wdata           (i_io_wdata),
  .o_io_rdata           (o_io_rdata),
  .o_primary_port_bit   (o_primary_port_bit),
  .o_primary_port_oe    (o_primary_port_oe),
  .o_secondary_port_bit (o_secondary_port_bit),
  .o_secondary_port_oe  (o_secondary_port_oe),
  .i_irq_route          (i_irq_route),
  .o_irq_lines          (o_irq_lines)
);
`default_nettype wire

// ### dio_line_model.sv
// External digital lines facing the port pins
`timescale 1ns/100ps
`default_nettype none

module dio_line_model (
  // From the block
  input  wire logic [7:0] i_primary_out,
  input  wire logic [7:0] i_primary_oe,
  input  wire logic [3:0] i_secondary_out,
  input  wire logic [3:0] i_secondary_oe,
  // Far-side drivers
  input  wire logic [7:0] i_primary_ext,
  input  wire logic [3:0] i_secondary_ext,
  input  wire logic       i_strobe_ext,
  // Resolved levels
  output logic      [7:0] o_primary_level,
  output logic      [3:0] o_secondary_level,
  output logic            o_strobe
);
  // Block wins where it drives; source contention is not modelled
  assign o_primary_level   = (i_primary_out & i_primary_oe) | (i_primary_ext & ~i_primary_oe);
  assign o_secondary_level = (i_secondary_out & i_secondary_oe)
                           | (i_secondary_ext & ~i_secondary_oe);
  assign o_strobe          = i_strobe_ext;
endmodule
`default_nettype wire

// ### dio_port_with_pattern_irq_bench.sv
// Self-checking bench for the digital port block
`timescale 1ns/100ps
`default_nettype none

module dio_port_with_pattern_irq_bench;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [7:0]  wdata = 8'h00;
  logic [7:0]  rdata, p_out, p_oe, p_in;
  logic [7:0]  p_ext = 8'h00;
  logic [3:0]  s_out, s_oe, s_in;
  logic [3:0]  s_ext = 4'h9;
  logic        stb_ext = 1'b0;
  logic        stb;
  logic [2:0]  route = 3'h0;
  logic [4:0]  irq;
  int          n_mismatch = 0;
  int          check_count = 0;

  always #25 clk = ~clk;

  dio_port dio_port_inst (
    .i_ref_clk(clk), .i_reset_n(rst_n), .i_io_addr(addr), .i_io_rd(rd), .i_io_wr(wr),
    .i_io_wdata(wdata), .o_io_rdata(rdata), .i_primary_port_bit(p_in),
    .o_primary_port_bit(p_out), .o_primary_port_oe(p_oe), .i_secondary_port_bit(s_in),
    .o_secondary_port_bit(s_out), .o_secondary_port_oe(s_oe), .i_strobe(stb),
    .i_irq_route(route), .o_irq_lines(irq));

  dio_line_model dio_line_model_inst (
    .i_primary_out(p_out), .i_primary_oe(p_oe), .i_secondary_out(s_out),
    .i_secondary_oe(s_oe), .i_primary_ext(p_ext), .i_secondary_ext(s_ext),
    .i_strobe_ext(stb_ext), .o_primary_level(p_in), .o_secondary_level(s_in),
    .o_strobe(stb));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rc(input logic [11:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    #1 chk(rdata, e);
  endtask

  task automatic pins(input logic [7:0] v);
    @(posedge clk);
    p_ext <= v;
  endtask

  // Long enough for the strobe synchroniser and edge detector to see the edge
  task automatic strobe();
    @(posedge clk);
    stb_ext <= 1'b1;
    cyc(4);
    stb_ext <= 1'b0;
    cyc(4);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic t_reset();
    rc(12'hEC0, 8'h00);
    rc(12'hEC3, 8'h00);
    chk(p_oe, 8'h00);
    chk({4'h0, s_oe}, 8'h00);
    $display("reset test done");
  endtask

  task automatic t_primary();
    wr_reg(12'hEC3, 8'h01);
    wr_reg(12'hEC2, 8'hF0);
    wr_reg(12'hEC0, 8'hA5);
    pins(8'h3C);
    cyc(6);
    #1 chk(p_out & p_oe, 8'hA0);
    rc(12'hEC0, 8'hAC);
    rc(12'hEC2, 8'h00);
    rc(12'hEC4, 8'h00);
    $display("primary test done");
  endtask

  task automatic t_secondary();
    wr_reg(12'hEC3, 8'h00);
    rc(12'hEC1, 8'h09);
    wr_reg(12'hEC3, 8'h04);
    wr_reg(12'hEC1, 8'h06);
    rc(12'hEC1, 8'h06);
    chk({4'h0, s_out}, 8'h06);
    chk({4'h0, s_oe}, 8'h0F);
    wr_reg(12'hEC2, 8'hFF);
    #1 chk(p_out, 8'h00);
    rc(12'hEC3, 8'h00);
    rc(12'hEC1, 8'h09);
    $display("secondary and clear test done");
  endtask

  task automatic t_strobe();
    wr_reg(12'hEC3, 8'h01);
    wr_reg(12'hEC2, 8'h00);
    pins(8'h5A);
    route <= 3'h1;
    wr_reg(12'hEC3, 8'h0B);
    cyc(4);
    strobe();
    #1 chk({3'h0, irq}, 8'h01);
    for (int r = 0; r < 6; r++) begin
      @(posedge clk);
      route <= 3'(r);
      @(negedge clk);
      chk({3'h0, irq}, r == 0 ? 8'h00 : 8'(1 << (r - 1)));
    end
    route <= 3'h1;
    pins(8'h33);
    strobe();
    rc(12'hEC2, 8'h5A);
    wr_reg(12'hEC3, 8'h08);
    #1 chk({3'h0, irq}, 8'h01);
    rc(12'hEC2, 8'h00);
    chk({3'h0, irq}, 8'h00);
    $display("strobe test done");
  endtask

  task automatic t_event();
    wr_reg(12'hEC3, 8'h12);
    wr_reg(12'hEC2, 8'hF0);
    wr_reg(12'hEC3, 8'h10);
    route <= 3'h3;
    cyc(12);
    rc(12'hEC2, 8'h00);
    pins(8'hB3);
    cyc(12);
    #1 chk({3'h0, irq}, 8'h00);
    pins(8'hB2);
    cyc(12);
    #1 chk({3'h0, irq}, 8'h04);
    rc(12'hEC3, 8'h50);
    rc(12'hEC2, 8'h00);
    cyc(12);
    #1 chk({3'h0, irq}, 8'h00);
    $display("event test done");
  endtask

  task automatic t_match();
    wr_reg(12'hEC3, 8'h1B);
    wr_reg(12'hEC2, 8'h81);
    rc(12'hEC2, 8'h81);
    wr_reg(12'hEC3, 8'h1A);
    wr_reg(12'hEC2, 8'h00);
    wr_reg(12'hEC3, 8'h18);
    rc(12'hEC2, 8'h00);
    pins(8'h81);
    cyc(12);
    #1 chk({3'h0, irq}, 8'h04);
    wr_reg(12'hEC3, 8'h1A);
    wr_reg(12'hEC2, 8'hFF);
    wr_reg(12'hEC3, 8'h18);
    rc(12'hEC2, 8'h00);
    cyc(12);
    #1 chk({3'h0, irq}, 8'h00);
    $display("match test done");
  endtask

  initial begin
    cyc(6);
    rst_n <= 1'b1;
    cyc(4);
    t_reset();
    t_primary();
    t_secondary();
    t_strobe();
    t_event();
    t_match();
    wrap_up();
  end

  // Whole run is well under a thousand cycles
  initial begin
    cyc(5000);
    n_mismatch++;
    wrap_up();
  end
endmodule
`default_nettype wire
